// [shared/lime_params.svh]
// Constants for the literal, store and indirect move execution block
// How it works
// - Bank literal load writes six bits
// - Page literal load fills PC high latch
// - Accumulator literal load takes eight bits
// - Accumulator store writes selected file register
// - Indirect address: pointer, pointer plus/minus one, offset
// - Pointer steps at the store's clock edge, offset keeps it
// - Mode 00/01/10/11: pre/post increment/decrement
// - Sixteen-bit pointers wrap at both ends
// - Stores and pointer steps keep status flags
// - Indirect port redirects to pointed memory
// - Software reset resets device, clears flag
`ifndef LIME_PARAMS_SVH
`define LIME_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LIME_OFS_CTRL 8'h00
`define LIME_OFS_ACC 8'h04
`define LIME_OFS_BANK 8'h08
`define LIME_OFS_PC_HIGH_LATCH 8'h0C
`define LIME_OFS_FPTR0 8'h10
`define LIME_OFS_FPTR1 8'h14
`define LIME_OFS_PWRSTAT 8'h18
`define LIME_OFS_STATUS 8'h1C
`define LIME_OFS_INDP0 8'h20
`define LIME_OFS_INDP1 8'h24

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define LIME_CTRL_RST 1'b1
`define LIME_SWRST_FLAG_RST 1'b1
`define LIME_RESP_OKAY 2'b00
`define LIME_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------
`define LIME_OP_NOP 14'h0000
`define LIME_OP_RESET 14'h0001
`define LIME_PFX_WI 11'h003
`define LIME_PFX_WIK 7'h7F
`define LIME_PFX_LB 8'h05
`define LIME_PFX_WF 7'h01
`define LIME_PFX_LP 7'h63
`define LIME_PFX_LW 6'h30
`define LIME_FILE_INDP0 7'h00
`define LIME_FILE_INDP1 7'h01

`endif

// [shared/lime_pkg.sv]
// Types shared by the execution block
package lime_pkg;

    typedef enum logic [3:0] {
        LIME_NONE = 4'b0000,
        LIME_NOP = 4'b0001,
        LIME_RESET = 4'b0010,
        LIME_LB = 4'b0011,
        LIME_LP = 4'b0100,
        LIME_LW = 4'b0101,
        LIME_WF = 4'b0110,
        LIME_WI = 4'b0111,
        LIME_WIK = 4'b1000
    } lime_op_t;

    typedef enum logic [1:0] {
        LIME_PRE_INC = 2'b00,
        LIME_PRE_DEC = 2'b01,
        LIME_POST_INC = 2'b10,
        LIME_POST_DEC = 2'b11
    } lime_ptr_mode_t;

endpackage

// [shared/lime_mem_if.sv]
// Data memory port bundle between the core and its memory
`timescale 1ns/1ps
`default_nettype none
interface lime_mem_if #(parameter int AW = 11);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// [verilog/lime_data_mem.sv]
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module lime_data_mem #(parameter int AW = 11) (
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    lime_mem_if.mem mif
);
    logic [7:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk_sys) begin
        if (mif.wr_en) begin
            cells[mif.wr_addr] <= mif.wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mif.rd_data <= 8'h00;
        end else if (mif.rd_en) begin
            mif.rd_data <= cells[mif.rd_addr];
        end
    end
endmodule
`default_nettype wire

// [verilog/lime_core.sv]
// Execution core for literal loads, accumulator stores and indirect stores
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lime_params.svh"
module lime_core
    import lime_pkg::*;
#(
    parameter int DMEM_AW = 11
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    output logic instr_ready,
    output logic dev_reset_req,
    output logic [7:0] acc,
    output logic [5:0] bank_select,
    output logic [6:0] pc_high_latch,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------------------------------
    // Reset synchroniser and software reset
    // ----------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;
    logic soft_rst;
    logic exec_en;
    logic sw_reset_flag;
    logic [7:0] core_status;
    logic [15:0] file_pointer [0:1];
    lime_op_t op;
    lime_ptr_mode_t mode;
    logic ptr_sel;
    logic ptr_upd;
    logic [15:0] sel_fp;
    logic [15:0] next_fp;
    logic [15:0] wa;
    logic instr_fire;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= (op == LIME_RESET);
        end
    end
    assign dev_reset_req = soft_rst;

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    assign instr_ready = exec_en & ~soft_rst;
    assign instr_fire = instr_valid & instr_ready;

    always_comb begin
        op = LIME_NONE;
        mode = lime_ptr_mode_t'(instr_word[1:0]);
        ptr_sel = instr_word[2];
        if (instr_fire) begin
            if (instr_word == `LIME_OP_NOP) begin
                op = LIME_NOP;
            end else if (instr_word == `LIME_OP_RESET) begin
                op = LIME_RESET;
            end else if (instr_word[13:3] == `LIME_PFX_WI) begin
                op = LIME_WI;
            end else if (instr_word[13:7] == `LIME_PFX_WIK) begin
                op = LIME_WIK;
                ptr_sel = instr_word[6];
            end else if (instr_word[13:6] == `LIME_PFX_LB) begin
                op = LIME_LB;
            end else if (instr_word[13:7] == `LIME_PFX_WF) begin
                op = LIME_WF;
                ptr_sel = instr_word[0];
            end else if (instr_word[13:7] == `LIME_PFX_LP) begin
                op = LIME_LP;
            end else if (instr_word[13:8] == `LIME_PFX_LW) begin
                op = LIME_LW;
            end
        end
    end

    // ----------------------------------------------------------------
    // Indirect address and pointer update
    // ----------------------------------------------------------------
    assign sel_fp = file_pointer[ptr_sel];
    assign ptr_upd = (op == LIME_WI);
    // Bit 0 of the mode picks decrement, bit 1 picks post update
    assign next_fp = mode[0] ? sel_fp - 16'h0001 : sel_fp + 16'h0001;

    always_comb begin
        if (op == LIME_WIK) begin
            wa = sel_fp + {{10{instr_word[5]}}, instr_word[5:0]};
        end else if (mode[1]) begin
            wa = sel_fp;
        end else begin
            wa = next_fp;
        end
    end

    // ----------------------------------------------------------------
    // Bus slave state
    // ----------------------------------------------------------------
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic rd_pend;
    logic [7:0] rd_addr_q;
    logic wr_mapped;
    logic [31:0] rd_word;
    logic rd_mapped;

    assign s_axi_awready = ~aw_full;
    assign s_axi_wready = ~w_full;
    assign s_axi_arready = ~rd_pend & ~s_axi_rvalid;
    // Instruction execution owns the register file in its cycle
    assign do_write = aw_full & w_full & ~s_axi_bvalid & ~instr_fire;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_comb begin
        case (aw_addr_q)
            `LIME_OFS_CTRL, `LIME_OFS_ACC, `LIME_OFS_BANK, `LIME_OFS_PC_HIGH_LATCH, `LIME_OFS_FPTR0,
            `LIME_OFS_FPTR1, `LIME_OFS_PWRSTAT, `LIME_OFS_STATUS, `LIME_OFS_INDP0, `LIME_OFS_INDP1: begin
                wr_mapped = 1'b1;
            end
            default: begin
                wr_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LIME_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_full <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `LIME_RESP_OKAY : `LIME_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Core registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            acc <= 8'h00;
        end else if (soft_rst) begin
            acc <= 8'h00;
        end else if (op == LIME_LW) begin
            acc <= instr_word[7:0];
        end else if (do_write && aw_addr_q == `LIME_OFS_ACC && w_strb_q[0]) begin
            acc <= w_data_q[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bank_select <= 6'h00;
            pc_high_latch <= 7'h00;
        end else if (soft_rst) begin
            bank_select <= 6'h00;
            pc_high_latch <= 7'h00;
        end else begin
            if (op == LIME_LB) begin
                bank_select <= instr_word[5:0];
            end else if (do_write && aw_addr_q == `LIME_OFS_BANK && w_strb_q[0]) begin
                bank_select <= w_data_q[5:0];
            end
            if (op == LIME_LP) begin
                pc_high_latch <= instr_word[6:0];
            end else if (do_write && aw_addr_q == `LIME_OFS_PC_HIGH_LATCH && w_strb_q[0]) begin
                pc_high_latch <= w_data_q[6:0];
            end
        end
    end

    // Status flags are touched only by software in this block
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            core_status <= 8'h00;
            exec_en <= `LIME_CTRL_RST;
        end else if (soft_rst) begin
            core_status <= 8'h00;
            exec_en <= `LIME_CTRL_RST;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q == `LIME_OFS_STATUS) begin
                core_status <= w_data_q[7:0];
            end
            if (aw_addr_q == `LIME_OFS_CTRL) begin
                exec_en <= w_data_q[0];
            end
        end
    end

    // Survives the software reset so that its cause stays visible
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sw_reset_flag <= `LIME_SWRST_FLAG_RST;
        end else if (op == LIME_RESET) begin
            sw_reset_flag <= 1'b0;
        end else if (do_write && aw_addr_q == `LIME_OFS_PWRSTAT && w_strb_q[0]) begin
            sw_reset_flag <= w_data_q[0];
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_fp
        always_ff @(posedge clk_sys or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                file_pointer[g] <= 16'h0000;
            end else if (soft_rst) begin
                file_pointer[g] <= 16'h0000;
            end else if (ptr_upd && ptr_sel == 1'(g)) begin
                file_pointer[g] <= next_fp;
            end else if (do_write && aw_addr_q == (g == 0 ? `LIME_OFS_FPTR0 : `LIME_OFS_FPTR1)) begin
                file_pointer[g] <= merge16(file_pointer[g], w_data_q, w_strb_q);
            end
        end
    end

    // ----------------------------------------------------------------
    // Data memory and indirect port
    // ----------------------------------------------------------------
    lime_mem_if #(.AW(DMEM_AW)) mif ();
    logic [15:0] mem_wa;
    logic [6:0] file_ofs;
    logic ind_wr;
    logic ind_rd;

    assign file_ofs = instr_word[6:0];
    assign ind_wr = do_write && w_strb_q[0] &&
        (aw_addr_q == `LIME_OFS_INDP0 || aw_addr_q == `LIME_OFS_INDP1);
    assign ind_rd = s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == `LIME_OFS_INDP0 || s_axi_araddr == `LIME_OFS_INDP1);

    always_comb begin
        mif.wr_en = 1'b0;
        mif.wr_data = acc;
        mem_wa = wa;
        if (op == LIME_WI || op == LIME_WIK) begin
            mif.wr_en = 1'b1;
        end else if (op == LIME_WF) begin
            mif.wr_en = 1'b1;
            if (file_ofs == `LIME_FILE_INDP0 || file_ofs == `LIME_FILE_INDP1) begin
                mem_wa = sel_fp;
            end else begin
                mem_wa = {3'b000, bank_select, file_ofs};
            end
        end else if (ind_wr) begin
            mif.wr_en = 1'b1;
            mif.wr_data = w_data_q[7:0];
            mem_wa = file_pointer[aw_addr_q[2]];
        end
    end
    assign mif.wr_addr = mem_wa[DMEM_AW-1:0];
    assign mif.rd_en = ind_rd;
    assign mif.rd_addr = file_pointer[s_axi_araddr[2]][DMEM_AW-1:0];

    lime_data_mem #(.AW(DMEM_AW)) u_mem (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .mif(mif.mem)
    );

    // ----------------------------------------------------------------
    // Register read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_mapped = 1'b1;
        rd_word = 32'h0000_0000;
        case (rd_addr_q)
            `LIME_OFS_CTRL: rd_word[0] = exec_en;
            `LIME_OFS_ACC: rd_word[7:0] = acc;
            `LIME_OFS_BANK: rd_word[5:0] = bank_select;
            `LIME_OFS_PC_HIGH_LATCH: rd_word[6:0] = pc_high_latch;
            `LIME_OFS_FPTR0: rd_word[15:0] = file_pointer[0];
            `LIME_OFS_FPTR1: rd_word[15:0] = file_pointer[1];
            `LIME_OFS_PWRSTAT: rd_word[0] = sw_reset_flag;
            `LIME_OFS_STATUS: rd_word[7:0] = core_status;
            `LIME_OFS_INDP0, `LIME_OFS_INDP1: rd_word[7:0] = mif.rd_data;
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_pend <= 1'b0;
            rd_addr_q <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LIME_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pend <= 1'b1;
                rd_addr_q <= s_axi_araddr;
            end else if (rd_pend) begin
                rd_pend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_mapped ? `LIME_RESP_OKAY : `LIME_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    a_bank_load: assert property ((op == LIME_LB) |=> bank_select == $past(instr_word[5:0]))
        else $error("bank literal not loaded");
    a_page_load: assert property ((op == LIME_LP) |=> pc_high_latch == $past(instr_word[6:0]))
        else $error("page literal not loaded");
    a_acc_load: assert property ((op == LIME_LW) |=> acc == $past(instr_word[7:0]) && $stable(bank_select))
        else $error("accumulator literal not loaded");
    a_file_store: assert property ((op == LIME_WF && file_ofs > 7'h01) |->
        mif.wr_en && mif.wr_data == acc && mem_wa == {3'b000, bank_select, file_ofs})
        else $error("accumulator store went wrong");
    a_pre_addr: assert property ((op == LIME_WI && mode == LIME_PRE_DEC) |-> mem_wa == sel_fp - 16'h0001)
        else $error("pre-decrement address wrong");
    a_post_step: assert property ((op == LIME_WI && !ptr_sel && mode == LIME_POST_INC) |->
        mem_wa == file_pointer[0] ##1 file_pointer[0] == $past(file_pointer[0]) + 16'h0001)
        else $error("post-increment step wrong");
    a_ptr_wrap: assert property ((op == LIME_WI && !ptr_sel && mode[0] && file_pointer[0] == 16'h0000) |=>
        file_pointer[0] == 16'hFFFF)
        else $error("pointer did not wrap");
    a_rel_keep: assert property ((op == LIME_WIK && ptr_sel) |=> $stable(file_pointer[1]))
        else $error("relative store moved pointer");
    a_flags_keep: assert property ((op inside {LIME_LB, LIME_LP, LIME_LW, LIME_WF, LIME_WI, LIME_WIK}) |=>
        $stable(core_status))
        else $error("status flags changed");
    a_indirect_redir: assert property ((op == LIME_WF && file_ofs == `LIME_FILE_INDP1) |->
        mem_wa == file_pointer[1])
        else $error("indirect port not redirected");
    a_soft_reset: assert property ((op == LIME_RESET) |=> soft_rst && !sw_reset_flag && !instr_ready ##1
        acc == 8'h00 && file_pointer[0] == 16'h0000)
        else $error("software reset incomplete");
    a_nop_quiet: assert property ((op == LIME_NOP) |-> !mif.wr_en ##1 $stable(acc) && $stable(pc_high_latch)
        && $stable(file_pointer[0]) && !soft_rst)
        else $error("no-op changed state");
endmodule
`default_nettype wire

// [sim/lime_core_tb.sv]
// Self-checking bench for the literal, store and indirect move execution core
`timescale 1ns/1ps
`default_nettype none
module lime_core_tb;
    typedef struct {string nm; logic [33:0] v;} lime_note_t;

    logic clk_sys, rst_n, instr_valid, instr_ready, dev_reset_req;
    logic [13:0] instr_word;
    logic [7:0] acc, s_axi_awaddr, s_axi_araddr, k, v;
    logic [5:0] bank_select;
    logic [6:0] pc_high_latch, f;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, n;
    logic [15:0] p0, pf, tgt;
    lime_note_t notes[$];
    lime_note_t note;
    int miscompares = 0;
    int total_checks = 0;

    lime_core #(.DMEM_AW(11)) lime_core_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .dev_reset_req(dev_reset_req), .acc(acc), .bank_select(bank_select),
        .pc_high_latch(pc_high_latch), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------
    // Response watcher
    // ------------------------------------------------
    always @(posedge clk_sys) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            note = notes.pop_front();
            total_checks++;
            if (s_axi_bvalid ? ({s_axi_bresp, 32'h0} !== note.v) : ({s_axi_rresp, s_axi_rdata} !== note.v)) begin
                miscompares++;
                $display("[FAIL] %s expected %h seen %h/%h %h", note.nm, note.v, s_axi_bresp, s_axi_rresp, s_axi_rdata);
            end
        end
    end

    // ------------------------------------------------
    // Drivers
    // ------------------------------------------------
    task automatic complete_run;
        if (notes.size() != 0) miscompares++;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic hang(input string nm);
        miscompares++;
        $display("[FAIL] %s expected handshake seen timeout", nm);
        complete_run();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic exec_seq(input logic [13:0] ws[$]);
        int c;
        for (int i = 0; i < ws.size(); i++) begin
            instr_valid <= 1'b1;
            instr_word <= ws[i];
            c = 0;
            @(negedge clk_sys);
            while (instr_ready !== 1'b1) begin
                c++;
                if (c > 50) hang("instr_ready");
                @(negedge clk_sys);
            end
            @(posedge clk_sys);
        end
        instr_valid <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input string nm);
        logic ta, tw, done;
        notes.push_back('{nm, {r, 32'h0}});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 1'b0;
        for (int c = 0; !done; c++) begin
            if (c > 50) hang(nm);
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid && s_axi_bready;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input string nm);
        logic ta, done;
        notes.push_back('{nm, {r, d}});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 1'b0;
        for (int c = 0; !done; c++) begin
            if (c > 50) hang(nm);
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid && s_axi_rready;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
        end
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        {rst_n, instr_valid, instr_word, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'he736));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(8'h00, 32'h1, 2'b00, "ctrl_reset");
        rd(8'h18, 32'h1, 2'b00, "reset_flag_reset");
        rd(8'h28, 32'h0, 2'b10, "unmapped_read");
        wr(8'h28, 32'h5, 2'b10, "unmapped_write");
        wr(8'h1C, 32'hA5, 2'b00, "status_write");
        $display("test reset_values done");
        for (int i = 0; i < 2; i++) begin
            k = (i == 0) ? 8'hFF : 8'($urandom);
            exec_seq('{{8'h05, k[5:0]}, {7'h63, k[6:0]}, {6'h30, k}, 14'h0000});
            rd(8'h08, {26'h0, k[5:0]}, 2'b00, "bank_select");
            rd(8'h0C, {25'h0, k[6:0]}, 2'b00, "pc_high_latch");
            rd(8'h04, {24'h0, k}, 2'b00, "acc");
            @(negedge clk_sys);
            chk("literal_ports", {11'h0, k[5:0], k[6:0], k}, {11'h0, bank_select, pc_high_latch, acc});
            @(posedge clk_sys);
        end
        $display("test literal_loads done");
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom);
            f = 7'd2 + 7'($urandom % 126);
            exec_seq('{{8'h05, 6'h05}, {6'h30, v}, {7'h01, f}});
            wr(8'h10 | 8'(i * 4), {21'h0, 11'h280 + {4'h0, f}}, 2'b00, "ptr_set");
            rd(8'h20 | 8'(i * 4), {24'h0, v}, 2'b00, "file_store");
            exec_seq('{{6'h30, ~v}, {7'h01, 7'(i)}});
            rd(8'h20 | 8'(i * 4), {24'h0, ~v}, 2'b00, "port_redirect");
            rd(8'h10 | 8'(i * 4), {21'h0, 11'h280 + {4'h0, f}}, 2'b00, "ptr_kept");
        end
        $display("test file_store done");
        for (int m = 0; m < 4; m++) begin
            n = (m == 3);
            v = 8'($urandom);
            p0 = m[0] ? 16'h0000 : 16'hFFFF;
            pf = m[0] ? 16'hFFFF : 16'h0000;
            tgt = m[1] ? p0 : pf;
            wr(8'h10 | {5'h0, n, 2'h0}, {16'h0, p0}, 2'b00, "ptr_set");
            exec_seq('{{6'h30, v}, {11'h003, n, 2'(m)}});
            rd(8'h10 | {5'h0, n, 2'h0}, {16'h0, pf}, 2'b00, "ptr_after_step");
            wr(8'h10 | {5'h0, n, 2'h0}, {16'h0, tgt}, 2'b00, "ptr_set");
            rd(8'h20 | {5'h0, n, 2'h0}, {24'h0, v}, 2'b00, "indirect_target");
        end
        for (int j = 0; j < 2; j++) begin
            n = j[0];
            v = 8'($urandom);
            k = (j == 0) ? 8'h20 : 8'h1F;
            wr(8'h10 | {5'h0, n, 2'h0}, 32'h100, 2'b00, "ptr_set");
            exec_seq('{{6'h30, v}, {7'h7F, n, k[5:0]}});
            rd(8'h10 | {5'h0, n, 2'h0}, 32'h100, 2'b00, "ptr_after_offset");
            wr(8'h10 | {5'h0, n, 2'h0}, (j == 0) ? 32'hE0 : 32'h11F, 2'b00, "ptr_set");
            rd(8'h20 | {5'h0, n, 2'h0}, {24'h0, v}, 2'b00, "offset_target");
        end
        rd(8'h1C, 32'hA5, 2'b00, "status_kept");
        $display("test indirect_store done");
        exec_seq('{14'h0001});
        @(negedge clk_sys);
        chk("reset_pulse", 32'h2, {30'h0, dev_reset_req, instr_ready});
        repeat (2) @(posedge clk_sys);
        rd(8'h04, 32'h0, 2'b00, "acc_after_reset");
        rd(8'h08, 32'h0, 2'b00, "bank_after_reset");
        rd(8'h18, 32'h0, 2'b00, "reset_flag_cleared");
        rd(8'h00, 32'h1, 2'b00, "ctrl_after_reset");
        wr(8'h00, 32'h0, 2'b00, "ctrl_off");
        instr_valid <= 1'b1;
        instr_word <= {6'h30, 8'h77};
        repeat (5) @(posedge clk_sys);
        instr_valid <= 1'b0;
        rd(8'h04, 32'h0, 2'b00, "acc_refused");
        @(negedge clk_sys);
        chk("ports_after_reset", 32'h0, {11'h0, bank_select, pc_high_latch, acc});
        $display("test software_reset done");
        repeat (3) @(posedge clk_sys);
        complete_run();
    end
endmodule
`default_nettype wire
